// File: src/seb_pkg.sv
/*
 shared external bus package: widths, lane positions, formats, states
 and the lane functions used by both bus ends, plus the bank decoding function used by the device end.
 assumes one clock; every bus input is sampled on that clock.
*/
package seb_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 48;
	localparam int USER_W = 40;
	localparam int BANKS  = 4;
	localparam int SHF_W  = 5;
	localparam int W32_LO = 16;
	localparam int E40_LO = 8;
	localparam int S16_LO = 16;
	localparam int B8_LO  = 16;
	localparam logic [ADDR_W-1:0] EXT_BASE = 32'h0040_0000;
	localparam logic [BANKS-1:0]  BS_IDLE  = 4'hF;
	localparam logic [BANKS-1:0]  BS_ONE   = 4'h1;
	localparam logic [1:0]        STEP_0   = 2'h0;
	localparam logic [1:0]        STEP_1   = 2'h1;
	localparam logic [1:0]        STEP_2   = 2'h2;

	typedef enum logic [1:0] {
		FMT_W32 = 2'h0,
		FMT_E40 = 2'h1,
		FMT_S16 = 2'h2,
		FMT_B8  = 2'h3
	} seb_fmt_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_DATA = 4'b1000
	} seb_st_t;

	// place right-justified user data on its lanes
	function automatic logic [DATA_W-1:0] sebPack(seb_fmt_t f, logic [USER_W-1:0] v);
		logic [DATA_W-1:0] d;
		d = '0;
		case (f)
			FMT_W32: d[W32_LO +: 32] = v[31:0];
			FMT_E40: d[E40_LO +: 40] = v;
			FMT_S16: d[S16_LO +: 16] = v[15:0];
			default: d[B8_LO +: 8] = v[7:0];
		endcase
		return d;
	endfunction

	// take user data off its lanes, right-justified
	function automatic logic [USER_W-1:0] sebUnpack(seb_fmt_t f, logic [DATA_W-1:0] d);
		logic [USER_W-1:0] v;
		v = '0;
		case (f)
			FMT_W32: v[31:0] = d[W32_LO +: 32];
			FMT_E40: v = d[E40_LO +: 40];
			FMT_S16: v[15:0] = d[S16_LO +: 16];
			default: v[7:0] = d[B8_LO +: 8];
		endcase
		return v;
	endfunction

	// active-low bank select from address and log2 bank size
	function automatic logic [BANKS-1:0] sebBankSel(logic [ADDR_W-1:0] a, logic [SHF_W-1:0] sh);
		logic [ADDR_W-1:0] idx;
		idx = (a - EXT_BASE) >> sh;
		if (a < EXT_BASE || idx >= BANKS) begin
			return BS_IDLE;
		end
		return ~(BS_ONE << idx[1:0]);
	endfunction
endpackage

// File: src/seb_bus_if.sv
/*
 shared external bus carrier: each end drives value and enable, the
 carrier resolves wire levels with the device end first.
 assumes the two ends never enable the same group together.
*/
`timescale 1ns/10ps
`default_nettype none
interface seb_bus_if;
	import seb_pkg::*;
	// device end drives
	logic [ADDR_W-1:0] devAddr;
	logic              devAddrOe;
	logic [DATA_W-1:0] devData;
	logic              devDataOe;
	logic [BANKS-1:0]  devBs;
	logic              devBsOe;
	logic              devRdN;
	logic              devWrN;
	logic              devStrOe;
	logic              devPage;
	// host end drives
	logic [ADDR_W-1:0] hostAddr;
	logic              hostAddrOe;
	logic [DATA_W-1:0] hostData;
	logic              hostDataOe;
	logic              hostRdN;
	logic              hostWrN;
	logic              hostStrOe;
	// resolved levels
	logic [ADDR_W-1:0] extAddressBus;
	logic              extAddrDriven;
	logic [DATA_W-1:0] extDataBus;
	logic              extDataDriven;
	logic [BANKS-1:0]  bankSelectN;
	logic              rdN;
	logic              wrN;
	logic              page;

	// wire levels; undriven strobes and selects read high
	assign extAddrDriven = devAddrOe | hostAddrOe;
	assign extAddressBus = devAddrOe ? devAddr : (hostAddrOe ? hostAddr : '0);
	assign extDataDriven = devDataOe | hostDataOe;
	assign extDataBus    = devDataOe ? devData : (hostDataOe ? hostData : '0);
	assign bankSelectN   = devBsOe ? devBs : BS_IDLE;
	assign rdN           = devStrOe ? devRdN : (hostStrOe ? hostRdN : 1'b1);
	assign wrN           = devStrOe ? devWrN : (hostStrOe ? hostWrN : 1'b1);
	assign page          = devBsOe & devPage;

	modport dev (
		output devAddr, devAddrOe, devData, devDataOe, devBs, devBsOe,
		output devRdN, devWrN, devStrOe, devPage,
		input  extAddressBus, extAddrDriven, extDataBus, extDataDriven, rdN, wrN
	);
	modport host (
		output hostAddr, hostAddrOe, hostData, hostDataOe, hostRdN, hostWrN, hostStrOe,
		input  extAddressBus, extDataBus, bankSelectN, rdN, wrN, page
	);
endinterface
`default_nettype wire

// File: src/seb_keeper.sv
/*
 bus keeper: passes a driven bus through and holds its last driven
 level while nobody drives it.
 assumes the driven flag is valid every cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module seb_keeper #(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rstn,
	// bus side
	input  wire logic [W-1:0] busIn,
	input  wire logic         driven,
	// kept level
	output logic [W-1:0]      kept
);
	logic [W-1:0] hold_ff;

	// remember last driven level
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hold_ff <= '0;
		end else if (driven) begin
			hold_ff <= busIn;
		end
	end

	assign kept = driven ? busIn : hold_ff;
endmodule
`default_nettype wire

// File: src/seb_dev_end.sv
/*
 device end of the shared external bus: masters external accesses
 with address, lane-packed data, bank selects and page flag, and
 serves slave accesses to its internal memory when not master.
 assumes isMaster is synchronous; holdReqN may be asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module seb_dev_end
	import seb_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// bus
	seb_bus_if.dev                 bus,
	// ownership and configuration
	input  wire logic              isMaster,
	input  wire logic              holdReqN,
	input  wire logic [SHF_W-1:0]  bankShift,
	input  wire logic [SHF_W-1:0]  pageShift,
	// master request
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire logic              reqCondFalse,
	input  wire seb_fmt_t          reqFmt,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [USER_W-1:0] reqData,
	output logic                   reqReady,
	// master read answer
	output logic                   rdValid,
	output logic [USER_W-1:0]      rdData,
	// slave access
	input  wire logic [DATA_W-1:0] slvRdData,
	output logic                   slvValid,
	output logic                   slvWrite,
	output logic [ADDR_W-1:0]      slvAddr,
	output logic [DATA_W-1:0]      slvData
);
	seb_st_t           state_ff;
	seb_st_t           nxt_state;
	logic              syncA_ff;
	logic              syncB_ff;
	logic              ready_ff;
	logic              isRead_ff;
	seb_fmt_t          fmt_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic              addrOe_ff;
	logic [DATA_W-1:0] dataOut_ff;
	logic              dataOe_ff;
	logic [BANKS-1:0]  bs_ff;
	logic              rdN_ff;
	logic              wrN_ff;
	logic              page_ff;
	logic [ADDR_W-1:0] lastPage_ff;
	logic              pageValid_ff;
	logic              rdValid_ff;
	logic [USER_W-1:0] rdData_ff;
	logic [1:0]        slvStep_ff;
	logic              slvValid_ff;
	logic              slvWrite_ff;
	logic [ADDR_W-1:0] slvAddr_ff;
	logic [DATA_W-1:0] slvData_ff;
	logic [ADDR_W-1:0] keptAddr;
	logic [DATA_W-1:0] keptData;
	logic              accept;
	logic [BANKS-1:0]  reqBs;
	logic [ADDR_W-1:0] reqPage;
	logic              slvStrobe;

	// keepers so undriven inputs never float
	seb_keeper #(.W(ADDR_W)) addrKeep (
		.clock  (clock),
		.rstn   (rstn),
		.busIn  (bus.extAddressBus),
		.driven (bus.extAddrDriven),
		.kept   (keptAddr)
	);
	seb_keeper #(.W(DATA_W)) dataKeep (
		.clock  (clock),
		.rstn   (rstn),
		.busIn  (bus.extDataBus),
		.driven (bus.extDataDriven),
		.kept   (keptData)
	);

	// two-flop synchroniser for the asynchronous hold request
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			syncA_ff <= 1'b1;
			syncB_ff <= 1'b1;
		end else begin
			syncA_ff <= holdReqN;
			syncB_ff <= syncA_ff;
		end
	end

	// request decode
	assign accept    = reqValid & ready_ff & isMaster;
	assign reqBs     = sebBankSel(reqAddr, bankShift);
	assign reqPage   = reqAddr >> pageShift;
	assign slvStrobe = ~isMaster & ~(bus.rdN & bus.wrN);

	// master sequence: address, wait, data, back to idle
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_state = ST_ADDR;
				end
			end
			ST_ADDR: nxt_state = ST_WAIT;
			ST_WAIT: nxt_state = ST_DATA;
			ST_DATA: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ready only while idle, master and not held off
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= (nxt_state == ST_IDLE) & isMaster & syncB_ff;
		end
	end

	// address, bank selects and strobes, launched together
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			addr_ff   <= '0;
			bs_ff     <= BS_IDLE;
			rdN_ff    <= 1'b1;
			wrN_ff    <= 1'b1;
			isRead_ff <= 1'b0;
			fmt_ff    <= FMT_W32;
		end else if (accept) begin
			addr_ff   <= reqAddr;
			bs_ff     <= reqBs;
			rdN_ff    <= reqWrite | reqCondFalse;
			wrN_ff    <= ~reqWrite | reqCondFalse;
			isRead_ff <= ~reqWrite & ~reqCondFalse;
			fmt_ff    <= reqFmt;
		end else if (state_ff == ST_DATA) begin
			bs_ff  <= BS_IDLE;
			rdN_ff <= 1'b1;
			wrN_ff <= 1'b1;
		end
	end

	// address, select and strobe enables only while master, released otherwise
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			addrOe_ff <= 1'b0;
		end else begin
			addrOe_ff <= isMaster;
		end
	end

	// page flag on bank 0 page crossing
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			page_ff      <= 1'b0;
			lastPage_ff  <= '0;
			pageValid_ff <= 1'b0;
		end else if (accept) begin
			page_ff <= ~reqBs[0] & (~pageValid_ff | (reqPage != lastPage_ff));
			if (!reqBs[0]) begin
				lastPage_ff  <= reqPage;
				pageValid_ff <= 1'b1;
			end
		end else if (state_ff == ST_DATA) begin
			page_ff <= 1'b0;
		end
	end

	// data lanes: master writes, or answer to a slave read
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dataOut_ff <= '0;
			dataOe_ff  <= 1'b0;
		end else if (accept) begin
			dataOut_ff <= sebPack(reqFmt, reqData);
			dataOe_ff  <= reqWrite & ~reqCondFalse;
		end else if (isMaster) begin
			if (state_ff == ST_DATA) begin
				dataOe_ff <= 1'b0;
			end
		end else if (slvStrobe & ~bus.rdN & (slvStep_ff == STEP_1)) begin
			dataOut_ff <= slvRdData;
			dataOe_ff  <= 1'b1;
		end else if (!slvStrobe) begin
			dataOe_ff <= 1'b0;
		end
	end

	// master read answer from the kept data lanes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdValid_ff <= 1'b0;
			rdData_ff  <= '0;
		end else begin
			rdValid_ff <= (state_ff == ST_DATA) & isRead_ff;
			if ((state_ff == ST_DATA) & isRead_ff) begin
				rdData_ff <= sebUnpack(fmt_ff, keptData);
			end
		end
	end

	// slave access: take address as input, pulse once per strobe
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			slvStep_ff  <= STEP_0;
			slvValid_ff <= 1'b0;
			slvWrite_ff <= 1'b0;
			slvAddr_ff  <= '0;
			slvData_ff  <= '0;
		end else begin
			slvValid_ff <= slvStrobe & (slvStep_ff == STEP_0);
			if (!slvStrobe) begin
				slvStep_ff <= STEP_0;
			end else if (slvStep_ff == STEP_0) begin
				slvStep_ff  <= STEP_1;
				slvWrite_ff <= ~bus.wrN;
				slvAddr_ff  <= keptAddr;
				slvData_ff  <= keptData;
			end else begin
				slvStep_ff <= STEP_2;
			end
		end
	end

	// bus side
	assign bus.devAddr   = addr_ff;
	assign bus.devAddrOe = addrOe_ff;
	assign bus.devData   = dataOut_ff;
	assign bus.devDataOe = dataOe_ff;
	assign bus.devBs     = bs_ff;
	assign bus.devBsOe   = addrOe_ff;
	assign bus.devRdN    = rdN_ff;
	assign bus.devWrN    = wrN_ff;
	assign bus.devStrOe  = addrOe_ff;
	assign bus.devPage   = page_ff;
	// user side
	assign reqReady = ready_ff;
	assign rdValid  = rdValid_ff;
	assign rdData   = rdData_ff;
	assign slvValid = slvValid_ff;
	assign slvWrite = slvWrite_ff;
	assign slvAddr  = slvAddr_ff;
	assign slvData  = slvData_ff;
endmodule
`default_nettype wire

// File: src/seb_host_end.sv
/*
 host end of the shared external bus: when granted it masters accesses
 to the device's internal memory; otherwise it answers the device as
 external memory, with read data two registered cycles after the strobe.
 assumes hostGrant is the inverse of the device's isMaster.
*/
`timescale 1ns/10ps
`default_nettype none
module seb_host_end
	import seb_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// bus
	seb_bus_if.host                bus,
	// ownership
	input  wire logic              hostGrant,
	// host request
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire seb_fmt_t          reqFmt,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [USER_W-1:0] reqData,
	output logic                   reqReady,
	output logic                   rdValid,
	output logic [USER_W-1:0]      rdData,
	// external memory side
	input  wire logic [DATA_W-1:0] memRdData,
	output logic                   memValid,
	output logic                   memWrite,
	output logic [BANKS-1:0]       memBankN,
	output logic                   memPage,
	output logic [ADDR_W-1:0]      memAddr,
	output logic [DATA_W-1:0]      memData
);
	seb_st_t           state_ff;
	logic              ready_ff;
	logic              isRead_ff;
	seb_fmt_t          fmt_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] dataOut_ff;
	logic              dataOe_ff;
	logic              rdN_ff;
	logic              wrN_ff;
	logic              rdValid_ff;
	logic [USER_W-1:0] rdData_ff;
	logic [1:0]        memStep_ff;
	logic              memValid_ff;
	logic              memWrite_ff;
	logic [BANKS-1:0]  memBank_ff;
	logic              memPage_ff;
	logic [ADDR_W-1:0] memAddr_ff;
	logic [DATA_W-1:0] memData_ff;
	logic              accept;
	logic              devStrobe;

	assign accept    = reqValid & ready_ff & hostGrant;
	assign devStrobe = ~hostGrant & ~(bus.rdN & bus.wrN);

	// master sequence, launch of address and strobes, capture of read data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_ff   <= ST_IDLE;
			ready_ff   <= 1'b0;
			addr_ff    <= '0;
			rdN_ff     <= 1'b1;
			wrN_ff     <= 1'b1;
			isRead_ff  <= 1'b0;
			fmt_ff     <= FMT_W32;
			rdValid_ff <= 1'b0;
			rdData_ff  <= '0;
		end else begin
			rdValid_ff <= (state_ff == ST_DATA) & isRead_ff;
			case (state_ff)
				ST_IDLE: begin
					ready_ff <= hostGrant & ~accept;
					if (accept) begin
						state_ff  <= ST_ADDR;
						addr_ff   <= reqAddr;
						rdN_ff    <= reqWrite;
						wrN_ff    <= ~reqWrite;
						isRead_ff <= ~reqWrite;
						fmt_ff    <= reqFmt;
					end
				end
				ST_ADDR: state_ff <= ST_WAIT;
				ST_WAIT: state_ff <= ST_DATA;
				default: begin
					state_ff <= ST_IDLE;
					ready_ff <= hostGrant;
					rdN_ff   <= 1'b1;
					wrN_ff   <= 1'b1;
					if (isRead_ff) begin
						rdData_ff <= sebUnpack(fmt_ff, bus.extDataBus);
					end
				end
			endcase
		end
	end

	// data lanes: own writes, or memory answer to a device read
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dataOut_ff <= '0;
			dataOe_ff  <= 1'b0;
		end else if (accept) begin
			dataOut_ff <= sebPack(reqFmt, reqData);
			dataOe_ff  <= reqWrite;
		end else if (hostGrant) begin
			if (state_ff == ST_DATA) begin
				dataOe_ff <= 1'b0;
			end
		end else if (devStrobe & ~bus.rdN & (memStep_ff == STEP_1)) begin
			dataOut_ff <= memRdData;
			dataOe_ff  <= 1'b1;
		end else if (!devStrobe) begin
			dataOe_ff <= 1'b0;
		end
	end

	// external memory: one pulse per device strobe
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			memStep_ff  <= STEP_0;
			memValid_ff <= 1'b0;
			memWrite_ff <= 1'b0;
			memBank_ff  <= BS_IDLE;
			memPage_ff  <= 1'b0;
			memAddr_ff  <= '0;
			memData_ff  <= '0;
		end else begin
			memValid_ff <= devStrobe & (memStep_ff == STEP_0);
			if (!devStrobe) begin
				memStep_ff <= STEP_0;
			end else if (memStep_ff == STEP_0) begin
				memStep_ff  <= STEP_1;
				memWrite_ff <= ~bus.wrN;
				memBank_ff  <= bus.bankSelectN;
				memPage_ff  <= bus.page;
				memAddr_ff  <= bus.extAddressBus;
				memData_ff  <= bus.extDataBus;
			end else begin
				memStep_ff <= STEP_2;
			end
		end
	end

	// bus side: address and strobes only while granted; data lanes also answer device reads
	assign bus.hostAddr   = addr_ff;
	assign bus.hostAddrOe = hostGrant;
	assign bus.hostData   = dataOut_ff;
	assign bus.hostDataOe = dataOe_ff;
	assign bus.hostRdN    = rdN_ff;
	assign bus.hostWrN    = wrN_ff;
	assign bus.hostStrOe  = hostGrant;
	// user side
	assign reqReady = ready_ff;
	assign rdValid  = rdValid_ff;
	assign rdData   = rdData_ff;
	assign memValid = memValid_ff;
	assign memWrite = memWrite_ff;
	assign memBankN = memBank_ff;
	assign memPage  = memPage_ff;
	assign memAddr  = memAddr_ff;
	assign memData  = memData_ff;
endmodule
`default_nettype wire

// File: sim/seb_bus_props.sv
/*
 checker for the shared bus carrier: selects, strobes, page and ownership.
 assumes it sits beside the carrier that joins the two ends, on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module seb_bus_props
	import seb_pkg::*;
(
	// clock and reset
	input wire logic              clock,
	input wire logic              rstn,
	// carrier signals
	input wire logic [ADDR_W-1:0] extAddressBus,
	input wire logic              devAddrOe,
	input wire logic              hostAddrOe,
	input wire logic              devDataOe,
	input wire logic              devBsOe,
	input wire logic              devStrOe,
	input wire logic              hostStrOe,
	input wire logic [BANKS-1:0]  bankSelectN,
	input wire logic              rdN,
	input wire logic              wrN,
	input wire logic              page
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// ownership, select decoding, strobe lengths and page
	chk_one_addr_owner: assert property (!(devAddrOe && hostAddrOe))
		else $error("both ends drive the address bus");
	chk_bs_one_hot: assert property (bankSelectN != BS_IDLE |-> $countones(~bankSelectN) == 1)
		else $error("more than one bank select active");
	chk_bs_three_cycles: assert property ($fell(&bankSelectN) |-> (!(&bankSelectN))[*3] ##1 (&bankSelectN))
		else $error("bank select active for the wrong length");
	chk_bs_addr_steady: assert property
		((!(&bankSelectN) && !$fell(&bankSelectN)) |-> $stable(extAddressBus) && $stable(bankSelectN))
		else $error("address or select moved inside an access");
	chk_bs_needs_master: assert property ($fell(&bankSelectN) |-> devAddrOe && !hostAddrOe)
		else $error("bank select without the device owning the address");
	chk_page_bank0: assert property (page |-> !bankSelectN[0])
		else $error("page flag outside bank 0");
	chk_host_no_bs: assert property (hostStrOe |-> (&bankSelectN) && !devBsOe)
		else $error("bank select while the host masters");
	chk_rd_strobe_len: assert property ($fell(rdN) |-> (!rdN)[*3] ##1 rdN)
		else $error("read strobe length wrong");
	chk_wr_strobe_len: assert property ($fell(wrN) |-> (!wrN)[*3] ##1 wrN)
		else $error("write strobe length wrong");
	chk_rd_no_drive: assert property ((!rdN && devStrOe) |-> !devDataOe)
		else $error("device drives data during its own read");

	// main scenarios
	cov_dev_read: cover property ($fell(rdN) && devStrOe);
	cov_host_write: cover property ($fell(wrN) && hostStrOe);
	cov_page: cover property (page);
endmodule
`default_nettype wire

// File: sim/test_shared_ext_bus_addr_data_select.sv
/*
 testbench: device end and host end joined by the carrier; each masters in turn.
 assumes the carrier gives device priority and both ends run on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_shared_ext_bus_addr_data_select;
	import seb_pkg::*;
	typedef struct {logic [31:0] a; logic [3:0] bs; logic [47:0] d; logic [47:0] m; logic w; logic pg;} seb_exp_t;
	logic clock = 0, rstn = 0, isMaster = 1, hostGrant = 0, holdReqN = 1;
	logic [SHF_W-1:0] bankShift = 5'h10, pageShift = 5'h08;
	logic reqValid = 0, reqWrite = 0, reqCondFalse = 0;
	seb_fmt_t reqFmt = FMT_W32;
	logic [31:0] reqAddr = '0, a, lastPg;
	logic [39:0] reqData = '0, dRdData, hRdData;
	logic [47:0] rdSrc = '0, slvData, memData;
	logic [31:0] slvAddr, memAddr;
	logic [3:0] memBankN;
	logic dReady, hReady, dRdValid, hRdValid, slvValid, slvWrite, memValid, memWrite, memPage, first = 1;
	int n_errors = 0, check_count = 0, cyc = 0;
	seb_exp_t qM[$];
	logic [39:0] qR[$];

	seb_bus_if i_seb_bus_if ();
	seb_dev_end i_seb_dev_end (.clock(clock), .rstn(rstn), .bus(i_seb_bus_if.dev), .isMaster(isMaster),
		.holdReqN(holdReqN), .bankShift(bankShift), .pageShift(pageShift), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqCondFalse(reqCondFalse), .reqFmt(reqFmt), .reqAddr(reqAddr), .reqData(reqData),
		.reqReady(dReady), .rdValid(dRdValid), .rdData(dRdData), .slvRdData(rdSrc), .slvValid(slvValid),
		.slvWrite(slvWrite), .slvAddr(slvAddr), .slvData(slvData));
	seb_host_end i_seb_host_end (.clock(clock), .rstn(rstn), .bus(i_seb_bus_if.host), .hostGrant(hostGrant),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqFmt(reqFmt), .reqAddr(reqAddr), .reqData(reqData),
		.reqReady(hReady), .rdValid(hRdValid), .rdData(hRdData), .memRdData(rdSrc), .memValid(memValid),
		.memWrite(memWrite), .memBankN(memBankN), .memPage(memPage), .memAddr(memAddr), .memData(memData));
	seb_bus_props i_seb_bus_props (.clock(clock), .rstn(rstn), .extAddressBus(i_seb_bus_if.extAddressBus),
		.devAddrOe(i_seb_bus_if.devAddrOe), .hostAddrOe(i_seb_bus_if.hostAddrOe),
		.devDataOe(i_seb_bus_if.devDataOe), .devBsOe(i_seb_bus_if.devBsOe), .devStrOe(i_seb_bus_if.devStrOe),
		.hostStrOe(i_seb_bus_if.hostStrOe), .bankSelectN(i_seb_bus_if.bankSelectN), .rdN(i_seb_bus_if.rdN),
		.wrN(i_seb_bus_if.wrN), .page(i_seb_bus_if.page));

	// clock and hang guard
	always #50 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(string n, logic [47:0] e, logic [47:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// one access by device (h=0) or host (h=1); notes expectations first
	task automatic acc(bit h, logic w, logic cf, seb_fmt_t f, logic [31:0] ad, logic [39:0] v);
		int lo, wd;
		logic [47:0] mk;
		logic [31:0] ix;
		seb_exp_t e;
		lo = (f == FMT_E40) ? 8 : 16;
		wd = (f == FMT_W32) ? 32 : (f == FMT_E40) ? 40 : (f == FMT_S16) ? 16 : 8;
		mk = ((48'h1 << wd) - 48'h1) << lo;
		rdSrc = 48'({$urandom, $urandom});
		ix = (ad - EXT_BASE) >> bankShift;
		e.bs = (h || ix > 3) ? BS_IDLE : ~(4'h1 << ix[1:0]);
		e.pg = !e.bs[0] && (first || (ad >> pageShift) != lastPg);
		if (!e.bs[0]) begin
			first = 0;
			lastPg = ad >> pageShift;
		end
		e.a = ad;
		e.w = w;
		e.m = mk;
		e.d = (48'(v) << lo) & mk;
		if (!cf) qM.push_back(e);
		if (!cf && !w) qR.push_back(40'((rdSrc & mk) >> lo));
		reqValid = 1;
		reqWrite = w;
		reqCondFalse = cf;
		reqFmt = f;
		reqAddr = ad;
		reqData = v;
		while ((h ? hReady : dReady) !== 1'b1) @(posedge clock) #1;
		@(posedge clock) #1 reqValid = 0;
		chk("bankSelectN", 48'(e.bs), 48'(i_seb_bus_if.bankSelectN));
		if (cf) chk("strobes", 48'h3, 48'({i_seb_bus_if.rdN, i_seb_bus_if.wrN}));
		// keep the read source steady until the far end has captured it
		repeat (2) @(posedge clock);
		#1;
	endtask

	task automatic popM(bit s);
		seb_exp_t e;
		if (qM.size() == 0) begin
			chk("spare access", 48'h0, 48'h1);
			return;
		end
		e = qM.pop_front();
		chk("addr", 48'(e.a), s ? 48'(slvAddr) : 48'(memAddr));
		chk("write", 48'(e.w), s ? 48'(slvWrite) : 48'(memWrite));
		if (e.w) chk("lanes", e.d, (s ? slvData : memData) & e.m);
		if (!s) chk("memBankN", 48'(e.bs), 48'(memBankN));
		if (!s) chk("memPage", 48'(e.pg), 48'(memPage));
	endtask

	task automatic popR(logic [39:0] g);
		if (qR.size() == 0) chk("spare read", 48'h0, 48'h1);
		else chk("rdData", 48'(qR.pop_front()), 48'(g));
	endtask

	// watcher: takes the oldest note whenever a result shows
	always @(posedge clock) begin
		#2;
		if (memValid === 1'b1) popM(0);
		if (slvValid === 1'b1) popM(1);
		if (dRdValid === 1'b1) popR(dRdData);
		if (hRdValid === 1'b1) popR(hRdData);
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'h9c72));
		repeat (12) @(posedge clock);
		#1 rstn = 1;
		// device masters: each format in its own bank, write then read back
		for (int f = 0; f < 4; f++) begin
			a = EXT_BASE + (32'(f) << 16) + ($urandom & 32'hFFFF);
			acc(0, 1, 0, seb_fmt_t'(f), a, 40'({$urandom, $urandom}));
			acc(0, 0, 0, seb_fmt_t'(f), a, 40'h0);
		end
		acc(0, 0, 0, FMT_W32, EXT_BASE + (a & 32'hFFFF) + 32'h100, 40'h0);
		acc(0, 0, 0, FMT_S16, EXT_BASE + 32'h0005_0000, 40'h0);
		acc(0, 0, 1, FMT_W32, EXT_BASE + 32'h0002_0010, 40'h0);
		acc(0, 1, 1, FMT_E40, EXT_BASE + 32'h0003_0020, 40'h12_3456_789A);
		holdReqN = 0;
		repeat (4) @(posedge clock);
		#1 chk("holdReady", 48'h0, 48'(dReady));
		holdReqN = 1;
		$display("test device master done");
		// hand the bus over, then host masters into internal memory
		isMaster = 0;
		repeat (3) @(posedge clock);
		#1 hostGrant = 1;
		for (int f = 0; f < 4; f++) begin
			a = $urandom & 32'h0003_FFFF;
			acc(1, 1, 0, seb_fmt_t'(f), a, 40'({$urandom, $urandom}));
			acc(1, 0, 0, seb_fmt_t'(f), a, 40'h0);
		end
		repeat (6) @(posedge clock);
		chk("notes left", 48'h0, 48'(qM.size() + qR.size()));
		$display("test host master done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
